// File: pkg/tma_pkg.sv
package tma_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int CNT_W    = 16;
  localparam int CHANNELS = 8;

  // ==========================================================
  // Counter constants
  // ==========================================================
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

  // ==========================================================
  // Modes and edge choices
  // ==========================================================
  typedef enum logic [3:0] {
    MODE_IDLE,
    MODE_INTERVAL,
    MODE_SQUARE,
    MODE_EVENT,
    MODE_DIVIDER,
    MODE_PULSE_INT,
    MODE_WIDTH,
    MODE_DELAY,
    MODE_CASCADE,
    MODE_SLAVE
  } tma_mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } tma_edge_t;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic             run;
    tma_mode_t        mode;
    tma_edge_t        edge_sel;
    logic [CNT_W-1:0] period;
  } tma_cfg_t;

  typedef struct packed {
    logic             irq;
    logic             wave;
    logic             cap_valid;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture;
  } tma_stat_t;

endpackage

// File: rtl/tma_chan.sv
module tma_chan #(
  parameter bit ALLOW_DIV = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire tma_pkg::tma_cfg_t cfg,
  input  wire logic              rise,
  input  wire logic              fall,
  input  wire logic              tick,
  output tma_pkg::tma_stat_t     stat
);
  import tma_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] capture;
  logic             irq;
  logic             wave;
  logic             cap_valid;
  logic             running;
  logic             valid_edge;
  logic             start_edge;
  logic             stop_edge;
  logic             expired;
  logic             step;

  function automatic logic edge_hit(input tma_edge_t sel, input logic r, input logic f);
    case (sel)
      EDGE_RISE: edge_hit = r;
      EDGE_FALL: edge_hit = f;
      EDGE_BOTH: edge_hit = r | f;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  assign valid_edge = edge_hit(cfg.edge_sel, rise, fall);
  // Rising start measures the high level, falling start the low level
  assign start_edge = (cfg.edge_sel == EDGE_FALL) ? fall : rise;
  assign stop_edge  = (cfg.edge_sel == EDGE_FALL) ? rise : fall;
  assign expired    = (count <= CNT_ONE);
  assign step       = (cfg.mode == MODE_CASCADE) ? tick : valid_edge;

  // ==========================================================
  // Counter, capture and interrupt
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count     <= CNT_ZERO;
      capture   <= CNT_ZERO;
      irq       <= 1'b0;
      cap_valid <= 1'b0;
      running   <= 1'b0;
    end else begin
      irq       <= 1'b0;
      cap_valid <= 1'b0;
      if (!cfg.run) begin
        count   <= cfg.period;
        running <= 1'b0;
      end else begin
        case (cfg.mode)
          MODE_INTERVAL, MODE_SQUARE: begin
            if (expired) begin
              count <= cfg.period;
              irq   <= 1'b1;
            end else begin
              count <= count - CNT_ONE;
            end
          end
          MODE_EVENT, MODE_CASCADE, MODE_DIVIDER: begin
            // Divider is only wired on the first channel
            if (step && (ALLOW_DIV || cfg.mode != MODE_DIVIDER)) begin
              if (expired) begin
                count <= cfg.period;
                irq   <= 1'b1;
              end else begin
                count <= count - CNT_ONE;
              end
            end
          end
          MODE_PULSE_INT: begin
            if (valid_edge) begin
              if (running) begin
                capture   <= count;
                cap_valid <= 1'b1;
                irq       <= 1'b1;
              end
              count   <= CNT_ZERO;
              running <= 1'b1;
            end else if (running) begin
              count <= count + CNT_ONE;
            end
          end
          MODE_WIDTH: begin
            if (!running && start_edge) begin
              count   <= CNT_ZERO;
              running <= 1'b1;
            end else if (running && stop_edge) begin
              capture   <= count;
              cap_valid <= 1'b1;
              irq       <= 1'b1;
              running   <= 1'b0;
            end else if (running) begin
              count <= count + CNT_ONE;
            end
          end
          MODE_DELAY: begin
            if (!running && valid_edge) begin
              count   <= cfg.period;
              running <= 1'b1;
            end else if (running) begin
              if (expired) begin
                irq     <= 1'b1;
                running <= 1'b0;
              end else begin
                count <= count - CNT_ONE;
              end
            end
          end
          MODE_SLAVE: begin
            // Master tick restarts the slave, so its period is the master's
            if (tick) begin
              count   <= cfg.period;
              running <= (cfg.period != CNT_ZERO);
            end else if (running) begin
              if (expired) begin
                irq     <= 1'b1;
                running <= 1'b0;
              end else begin
                count <= count - CNT_ONE;
              end
            end
          end
          default: begin
            count   <= cfg.period;
            running <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Output waveform
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wave <= 1'b0;
    end else if (!cfg.run) begin
      wave <= 1'b0;
    end else begin
      case (cfg.mode)
        MODE_SQUARE: wave <= wave ^ irq;
        MODE_DIVIDER: wave <= ALLOW_DIV ? (wave ^ irq) : 1'b0;
        MODE_SLAVE: begin
          if (tick) begin
            wave <= (cfg.period != CNT_ZERO);
          end else if (running && expired) begin
            wave <= 1'b0;
          end
        end
        default: wave <= 1'b0;
      endcase
    end
  end

  assign stat = '{irq: irq, wave: wave, cap_valid: cap_valid, count: count, capture: capture};

  // ==========================================================
  // Checks
  // ==========================================================
  chk_interval_reload: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.run && cfg.mode == MODE_INTERVAL && expired) ##1 (cfg.run && cfg.mode == MODE_INTERVAL)
      |-> irq && count == $past(cfg.period))
    else $error("interval reload missed");

  chk_square_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    (irq && cfg.run && cfg.mode == MODE_SQUARE) ##1 (cfg.run && cfg.mode == MODE_SQUARE)
      |-> wave != $past(wave))
    else $error("square wave did not toggle");

  chk_event_on_edge: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.run && cfg.mode == MODE_EVENT && !valid_edge) ##1 (cfg.run && cfg.mode == MODE_EVENT)
      |-> $stable(count) && !irq)
    else $error("event count moved without an edge");

  chk_divider_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (!ALLOW_DIV && cfg.mode == MODE_DIVIDER && $past(cfg.mode) == MODE_DIVIDER) |-> !wave)
    else $error("divider active on wrong channel");

  chk_capture_edge: assert property (@(posedge clk) disable iff (!reset_n)
    (cap_valid && $past(cfg.mode) == MODE_PULSE_INT) |-> $past(valid_edge) && capture == $past(count))
    else $error("capture without valid edge");

  chk_width_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.run && cfg.mode == MODE_WIDTH && running && stop_edge) |=> cap_valid && !running)
    else $error("width capture missed");

  chk_delay_once: assert property (@(posedge clk) disable iff (!reset_n)
    (irq && $past(cfg.mode) == MODE_DELAY) |-> !running)
    else $error("delay counter kept running");

  chk_slave_start: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.run && cfg.mode == MODE_SLAVE && tick && cfg.period != CNT_ZERO) |=> wave)
    else $error("slave pulse did not start");

  cov_pulse_capture: cover property (@(posedge clk) cap_valid && cfg.mode == MODE_PULSE_INT);
  cov_slave_end: cover property (@(posedge clk) cfg.mode == MODE_SLAVE && wave ##1 !wave);
  cov_delay_done: cover property (@(posedge clk) irq && cfg.mode == MODE_DELAY);

endmodule // tma_chan

// File: rtl/tma_timer_array.sv
// Contract
// - Eight independent channels, each with its own 16-bit counter.
// - Channels chain so one channel counts expiries of the nearest lower non-slave channel.
// - An independent channel ignores the modes of every other channel.
// - Interval mode raises its interrupt every programmed period.
// - Square mode toggles its output on each interrupt, 50% duty.
// - Event mode counts valid input edges, interrupting at the programmed count.
// - Only the first channel divides its input clock onto its output.
// - Pulse interval: start on valid edge, capture on the next one.
// - Width: start on one edge, capture on the opposite edge.
// - Delay: valid edge starts counting, interrupt after the programmed delay.
// - A master channel sets the cycle; slaves follow its ticks.
// - Master plus slave give a one-shot with set delay and width.
// - Master plus slave give PWM with set period and duty.
// - One master and up to seven slaves give shared-period PWM outputs.
module tma_timer_array #(
  parameter int CHANNELS = tma_pkg::CHANNELS,
  parameter int CNT_W    = tma_pkg::CNT_W
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire tma_pkg::tma_cfg_t [CHANNELS-1:0]  chan_cfg,
  // Bit 0 is first_chan_edge_in
  input  wire logic [CHANNELS-1:0]               chan_edge_in,
  // Bit 0 is first_chan_wave_out
  output logic [CHANNELS-1:0]                    chan_wave_out,
  output logic [CHANNELS-1:0]                    channel_irq,
  output logic [CHANNELS-1:0]                    chan_cap_valid,
  output logic [CHANNELS-1:0][CNT_W-1:0]         chan_count,
  output logic [CHANNELS-1:0][CNT_W-1:0]         chan_capture
);
  import tma_pkg::*;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // The shared-period check watches channels 0 to 2
  if (CHANNELS < 3 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 3 to 8");
  end
  if (CNT_W != tma_pkg::CNT_W) begin : g_bad_width
    $error("CNT_W must match the package counter width");
  end

  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] sync_prev;
  logic [CHANNELS-1:0] rise;
  logic [CHANNELS-1:0] fall;
  logic [CHANNELS-1:0] tick;
  tma_stat_t [CHANNELS-1:0] stat;

  // ==========================================================
  // Input synchronisers and edge detectors
  // ==========================================================
  // Two flops before any edge logic; the third flop only serves detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_prev <= '0;
    end else begin
      sync_a    <= chan_edge_in;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_prev;
  assign fall = ~sync_b & sync_prev;

  // ==========================================================
  // Master tick distribution
  // ==========================================================
  // A slave or cascade channel follows the nearest lower non-slave channel,
  // so one master can steer every slave in the unbroken run of slaves directly above it
  assign tick[0] = 1'b0;
  for (genvar n = 1; n < CHANNELS; n++) begin : g_tick
    assign tick[n] = (chan_cfg[n-1].mode == MODE_SLAVE) ? tick[n-1] : stat[n-1].irq;

    // A chained channel steps once for every expiry of the nearest lower non-slave channel
    chk_cascade_tick: assert property (@(posedge clk) disable iff (!reset_n)
      (chan_cfg[n].run && chan_cfg[n].mode == MODE_CASCADE && chan_cfg[n-1].mode != MODE_SLAVE
        && stat[n-1].irq && stat[n].count > CNT_ONE)
        ##1 (chan_cfg[n].run && chan_cfg[n].mode == MODE_CASCADE)
        |-> stat[n].count == $past(stat[n].count) - CNT_ONE)
      else $error("cascade channel did not step on the lower expiry");
  end

  // ==========================================================
  // Channels
  // ==========================================================
  for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
    // Each channel keeps private state; only the tick links them
    tma_chan #(
      .ALLOW_DIV (n == 0)
    ) u_chan (
      .clk     (clk),
      .reset_n (reset_n),
      .cfg     (chan_cfg[n]),
      .rise    (rise[n]),
      .fall    (fall[n]),
      .tick    (tick[n]),
      .stat    (stat[n])
    );

    assign chan_wave_out[n]  = stat[n].wave;
    assign channel_irq[n]    = stat[n].irq;
    assign chan_cap_valid[n] = stat[n].cap_valid;
    assign chan_count[n]     = stat[n].count;
    assign chan_capture[n]   = stat[n].capture;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_sync_latency: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(chan_edge_in[0]) ##1 chan_edge_in[0] |=> rise[0])
    else $error("input edge not seen two cycles later");

  chk_shared_period: assert property (@(posedge clk) disable iff (!reset_n)
    (chan_cfg[0].mode != MODE_SLAVE && channel_irq[0] && chan_cfg[1].run
      && chan_cfg[1].mode == MODE_SLAVE && chan_cfg[2].run && chan_cfg[2].mode == MODE_SLAVE)
      |=> chan_count[1] == $past(chan_cfg[1].period)
        && chan_count[2] == $past(chan_cfg[2].period))
    else $error("slaves did not restart on the same master expiry");

  cov_pwm_pair: cover property (@(posedge clk)
    chan_cfg[1].mode == MODE_SLAVE && tick[1] ##1 chan_wave_out[1]);
  cov_divider: cover property (@(posedge clk)
    chan_cfg[0].mode == MODE_DIVIDER && $rose(chan_wave_out[0]));

endmodule // tma_timer_array

// File: sim/tma_pin_model.sv
module tma_pin_model #(
  parameter int HI = 4,
  parameter int LO = 6
) (
  input  wire logic       clk,
  input  wire logic [7:0] en,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [8];

  initial pins = 8'h00;

  // ==========================================================
  // Pulse trains, one per pin, idle low while not enabled
  // ==========================================================
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!en[i]) begin
        pins[i] <= 1'b0;
        cnt[i]  <= 0;
      end else if (cnt[i] == 0) begin
        pins[i] <= ~pins[i];
        cnt[i]  <= pins[i] ? LO - 1 : HI - 1;
      end else begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule // tma_pin_model

// File: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tma_pkg::*;

  typedef struct {int ch; int gap; int cap;} tma_note_t;

  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  tma_cfg_t [7:0]       cfg = '0;
  logic [7:0]           pin_en = 8'h00;
  logic [7:0]           edge_in;
  logic [7:0]           wave;
  logic [7:0]           irq;
  logic [7:0]           cap_v;
  logic [7:0][15:0]     cnt;
  logic [7:0][15:0]     cap;
  tma_note_t            q[$];
  int                   fails = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;
  int                   idx;
  int                   seed = 32'ha87a;
  int                   pm;
  int                   last [8];
  int                   hits [8];
  int                   want [8];
  bit                   loose [8];

  tma_timer_array dut (.clk(clk), .reset_n(reset_n), .chan_cfg(cfg), .chan_edge_in(edge_in),
    .chan_wave_out(wave), .channel_irq(irq), .chan_cap_valid(cap_v), .chan_count(cnt),
    .chan_capture(cap));
  tma_pin_model #(.HI(4), .LO(6)) pins (.clk(clk), .en(pin_en), .pins(edge_in));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Loaded with run low first so the period is preloaded
  task automatic setc(input int c, input tma_mode_t m, input tma_edge_t e, input logic [15:0] p);
    cfg[c] = '{1'b0, m, e, p};
  endtask

  task automatic note_irq(input int c, input int gap, input int cp, input int n, input bit l);
    q.push_back('{c, -1, cp});
    repeat (n - 1) q.push_back('{c, gap, cp});
    want[c]  = n;
    loose[c] = l;
  endtask

  task automatic go();
    tick(1);
    for (int c = 0; c < 8; c++) cfg[c].run = (cfg[c].mode != MODE_IDLE);
    tick(1);
  endtask

  task automatic duty(input int c, input int w, input int e);
    int n;
    n = 0;
    repeat (w) begin
      @(negedge clk);
      if (wave[c] === 1'b1) n++;
    end
    chk("wave_high_cycles", e, n);
  endtask

  // Free-running channels may overshoot their notes, so only a minimum is held
  task automatic fin();
    for (int c = 0; c < 8; c++) begin
      if (loose[c]) chk("irq_hits_min", 1, hits[c] >= want[c]);
      else chk("irq_hits", want[c], hits[c]);
    end
    cfg = '0;
    tick(3);
    q.delete();
    for (int c = 0; c < 8; c++) begin
      hits[c]  = 0;
      want[c]  = 0;
      loose[c] = 0;
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Monitor: each interrupt takes the oldest note of its channel
  // ==========================================================
  always @(negedge clk) begin
    if (reset_n) begin
      for (int c = 0; c < 8; c++) begin
        if (irq[c] === 1'b1) begin
          idx = -1;
          foreach (q[k]) if (idx < 0 && q[k].ch == c) idx = k;
          if (idx < 0) begin
            if (!loose[c]) chk("irq_unexpected", 0, 1);
          end else begin
            if (q[idx].gap >= 0) chk("irq_gap", q[idx].gap, cyc - last[c]);
            if (q[idx].cap >= 0) begin
              chk("cap_valid", 1, cap_v[c]);
              chk("capture", q[idx].cap, cap[c]);
            end
            q.delete(idx);
          end
          last[c] = cyc;
          hits[c]++;
        end
      end
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (4) @(posedge clk);
    #2;
    chk("reset_irq", 0, irq);
    chk("reset_count", 0, cnt[3]);
    reset_n = 1'b1;
    // Idle channels hold their full 16-bit period
    for (int c = 0; c < 8; c++) setc(c, MODE_INTERVAL, EDGE_RISE, $random(seed));
    tick(2);
    for (int c = 0; c < 8; c++) chk("idle_count", cfg[c].period, cnt[c]);
    cfg = '0;
    tick(2);
    // All single-channel modes side by side, ten input pulses
    pm = 3 + ($unsigned($random(seed)) % 8);
    setc(0, MODE_DIVIDER, EDGE_BOTH, 16'h0002);
    setc(1, MODE_INTERVAL, EDGE_RISE, pm[15:0]);
    setc(2, MODE_SQUARE, EDGE_RISE, 16'h0005);
    setc(3, MODE_EVENT, EDGE_RISE, 16'h0003);
    setc(4, MODE_DIVIDER, EDGE_RISE, 16'h0001);
    setc(5, MODE_PULSE_INT, EDGE_FALL, 16'h0000);
    setc(6, MODE_WIDTH, EDGE_RISE, 16'h0000);
    setc(7, MODE_DELAY, EDGE_RISE, 16'h0004);
    note_irq(0, 10, -1, 10, 0);
    note_irq(1, pm, -1, 3, 1);
    note_irq(2, 5, -1, 3, 1);
    note_irq(3, 30, -1, 3, 0);
    note_irq(5, 10, 9, 9, 0);
    note_irq(6, 10, 3, 10, 0);
    note_irq(7, 10, -1, 10, 0);
    go();
    pin_en = 8'hff;
    tick(30);
    duty(2, 10, 5);
    duty(0, 20, 10);
    tick(37);
    pin_en = 8'h00;
    tick(30);
    chk("refused_divider_wave", 0, wave[4]);
    fin();
    // One master, seven slaves with their own duty
    pm = 8 + ($unsigned($random(seed)) % 8);
    setc(0, MODE_INTERVAL, EDGE_RISE, pm[15:0]);
    for (int c = 1; c < 8; c++) setc(c, MODE_SLAVE, EDGE_RISE, c[15:0]);
    for (int c = 0; c < 8; c++) note_irq(c, pm, -1, 3, 1);
    go();
    tick(3 * pm);
    for (int c = 1; c < 8; c++) duty(c, pm, c);
    tick(1);
    fin();
    // One-shot from a delay master, plus a chained pair
    setc(0, MODE_DELAY, EDGE_RISE, 16'h0006);
    setc(1, MODE_SLAVE, EDGE_RISE, 16'h0005);
    setc(2, MODE_INTERVAL, EDGE_RISE, 16'h0003);
    setc(3, MODE_CASCADE, EDGE_RISE, 16'h0004);
    note_irq(0, 0, -1, 1, 0);
    note_irq(1, 0, -1, 1, 0);
    note_irq(2, 3, -1, 3, 1);
    note_irq(3, 12, -1, 3, 1);
    go();
    pin_en = 8'h01;
    tick(3);
    pin_en = 8'h00;
    duty(1, 50, 5);
    tick(1);
    fin();
    end_sim();
  end
endmodule // testbench
